// ### logic/ep_access_pkg.sv
/*
 * Shared constants and carriers for the endpoint buffer access block:
 * command codes, status bit positions, buffer geometry.
 * Assumes a single 100 MHz core clock and synchronous active-low reset.
 */
package ep_access_pkg;
    localparam int          NUM_EP        = 16;
    localparam int          EP_IDX_W      = 4;
    localparam int          WORD_W        = 16;
    localparam int          ISO_MAX_BYTES = 1023;
    localparam int          BULK_MAX_BYTES = 32;
    localparam int          DEF_BUF_BYTES = 64;

    // Command codes
    localparam logic [7:0]  CMD_WR_FIRST  = 8'h01;
    localparam logic [7:0]  CMD_WR_LAST   = 8'h0F;
    localparam logic [7:0]  CMD_RD_CTRL   = 8'h10;
    localparam logic [7:0]  CMD_RD_FIRST  = 8'h12;
    localparam logic [7:0]  CMD_RD_LAST   = 8'h1F;
    localparam logic [7:0]  CMD_ST_FIRST  = 8'h50;
    localparam logic [7:0]  CMD_ST_LAST   = 8'h5F;

    // Status byte bit positions
    localparam int          ST_HALTED     = 7;
    localparam int          ST_FULL1      = 6;
    localparam int          ST_FULL0      = 5;
    localparam int          ST_TOGGLE     = 4;
    localparam int          ST_CLOBBER    = 3;
    localparam int          ST_SETUP      = 2;
    localparam int          ST_CPU_BUFFER_SELECT     = 1;

    localparam logic [7:0]  ST_RESET      = 8'h00;
    // Byte address of the packet-length word and of first data byte
    localparam int          LEN_WORD_ADDR = 0;
    localparam int          DMA_START     = 2;
    localparam int          PTR_STEP      = 2;

    // Per-endpoint events from the serial engine and command decoder
    typedef struct packed {
        logic stall_set;
        logic stall_clr;
        logic setup_rcvd;
        logic setup_done;
        logic setup_ack;
        logic full0;
        logic full1;
        logic toggle;
    } ep_event_t;

    // DMA side request
    typedef struct packed {
        logic                 start;
        logic                 step;
        logic                 write;
        logic [EP_IDX_W-1:0]  ep;
        logic [WORD_W-1:0]    wdata;
    } dma_req_t;
endpackage

// ### logic/ep_buffer_ram.sv
/*
 * Word-wide endpoint buffer memory with one write port and one
 * registered read port. Assumes the caller keeps addresses in range.
 */
`timescale 1ns/100ps
module ep_buffer_ram #(
    parameter int WORDS  = 512,
    parameter int WIDTH  = 16,
    parameter int ADDR_W = $clog2(WORDS)
) (
    // Clock
    input  wire logic              core_clk_i,
    // Write port
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]  wr_data_i,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [WIDTH-1:0]  rd_data_o
);
    logic [WIDTH-1:0] mem [WORDS];

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ### logic/ep_buffer_access.sv
/*
 * Command decoder, endpoint buffer pointer and endpoint status byte for
 * the peripheral controller's parallel microprocessor port.
 * Assumes bus strobes are single-cycle pulses already synchronous to
 * core_clk_i, and serial engine events are synchronous pulses/levels.
 */
`timescale 1ns/100ps
module ep_buffer_access #(
    parameter int BUF_BYTES = ep_access_pkg::DEF_BUF_BYTES,
    parameter int NUM_EP    = ep_access_pkg::NUM_EP,
    parameter int WORD_W    = ep_access_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_n_i,
    // Microprocessor port
    input  wire logic                         command_data_select_i,
    input  wire logic                         bus_wr_i,
    input  wire logic                         bus_rd_i,
    input  wire logic [WORD_W-1:0]            bus_data_i,
    output logic      [WORD_W-1:0]            bus_data_o,
    // Serial engine events, one per endpoint
    input  wire ep_access_pkg::ep_event_t [NUM_EP-1:0] ep_event_i,
    input  wire logic [NUM_EP-1:0]            double_buf_i,
    // DMA path
    input  wire ep_access_pkg::dma_req_t      dma_req_i,
    output logic      [WORD_W-1:0]            dma_data_o,
    // Interrupt flag clear and status
    output logic      [NUM_EP-1:0]            event_flag_clr_o,
    output logic      [NUM_EP-1:0]            endpoint_halted_o
);
    localparam int WPB    = (BUF_BYTES + 2 + 1) / 2;
    localparam int BANK_W = $clog2(WPB) + 1;
    localparam int WORDS  = NUM_EP * 2 * WPB;
    localparam int ADDR_W = $clog2(WORDS);
    localparam int IDX_W  = ep_access_pkg::EP_IDX_W;

    typedef enum logic [1:0] {IDLE, BUF_WR, BUF_RD, ST_RD} phase_t;

    phase_t                 phase;
    logic [IDX_W-1:0]       cur_ep;
    logic [BANK_W-1:0]      cpu_ptr;
    logic [BANK_W-1:0]      dma_ptr;
    logic                   dma_bank;
    logic [IDX_W-1:0]       dma_ep;
    logic [NUM_EP-1:0]      halted;
    logic [NUM_EP-1:0]      clobbered;
    logic [NUM_EP-1:0]      setup_present;
    logic [NUM_EP-1:0]      setup_busy;
    logic [NUM_EP-1:0]      cpu_buf;
    logic [7:0]             status_q;
    logic                   ram_for_cpu;

    function automatic logic in_range(input logic [7:0] c,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (c >= lo) && (c <= hi);
    endfunction

    // Command decode; upper data lines are don't-care
    // low byte command
    wire [7:0]  cmd_code   = bus_data_i[7:0];
    wire        cmd_strobe = bus_wr_i & command_data_select_i;
    wire        data_wr    = bus_wr_i & ~command_data_select_i;
    wire        data_rd    = bus_rd_i & ~command_data_select_i;
    wire        is_wr_cmd  = in_range(cmd_code, ep_access_pkg::CMD_WR_FIRST,
                                      ep_access_pkg::CMD_WR_LAST);
    wire        is_rd_cmd  = (cmd_code == ep_access_pkg::CMD_RD_CTRL) |
                             in_range(cmd_code, ep_access_pkg::CMD_RD_FIRST,
                                      ep_access_pkg::CMD_RD_LAST);
    wire        is_st_cmd  = in_range(cmd_code, ep_access_pkg::CMD_ST_FIRST,
                                      ep_access_pkg::CMD_ST_LAST);
    // Write 01h..0Fh maps to endpoint index 1..15, read 10h to 0 and 12h..1Fh to 2..15
    wire [IDX_W-1:0] cmd_ep = cmd_code[IDX_W-1:0];

    // Memory addressing: endpoint, bank, word
    wire [BANK_W-1:0] cpu_word = cpu_ptr >> 1;
    wire [BANK_W-1:0] dma_word = dma_ptr >> 1;
    wire [ADDR_W-1:0] cpu_addr = ADDR_W'((cur_ep * 2 + cpu_buf[cur_ep]) * WPB
                                         + cpu_word);
    wire [ADDR_W-1:0] dma_addr = ADDR_W'((dma_ep * 2 + dma_bank) * WPB
                                         + dma_word);
    wire              cpu_wr   = data_wr & (phase == BUF_WR);
    wire              dma_wr   = dma_req_i.step & dma_req_i.write;
    // CPU owns the read port only in its strobe cycle, so the DMA word
    // at the current pointer is refreshed whenever the bus is quiet
    wire              cpu_rd_now = data_rd & (phase == BUF_RD);
    wire              ram_we   = cpu_wr | dma_wr;
    wire [ADDR_W-1:0] ram_wa   = cpu_wr ? cpu_addr : dma_addr;
    wire [ADDR_W-1:0] ram_ra   = cpu_rd_now ? cpu_addr : dma_addr;
    // byte pairing lives in word layout, no lane swap
    wire [WORD_W-1:0] ram_wd   = cpu_wr ? bus_data_i : dma_req_i.wdata;
    wire [WORD_W-1:0] ram_rd;
    wire [BANK_W-1:0] bank_end = BANK_W'(2 * WPB);
    wire              dma_wrap = (dma_ptr + BANK_W'(ep_access_pkg::PTR_STEP))
                                 >= bank_end;

    ep_buffer_ram #(
        .WORDS  (WORDS),
        .WIDTH  (WORD_W)
    ) u_ram (
        .core_clk_i (core_clk_i),
        .wr_en_i    (ram_we),
        .wr_addr_i  (ram_wa),
        .wr_data_i  (ram_wd),
        .rd_addr_i  (ram_ra),
        .rd_data_o  (ram_rd)
    );

    // Status byte assembly; bit 0 reserved reads zero
    // full and toggle lanes
    wire [7:0] status_vec = {halted[cur_ep],
                             ep_event_i[cur_ep].full1,
                             ep_event_i[cur_ep].full0,
                             ep_event_i[cur_ep].toggle,
                             clobbered[cur_ep],
                             setup_present[cur_ep],
                             cpu_buf[cur_ep],
                             1'b0};

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            phase   <= IDLE;
            cur_ep  <= '0;
            cpu_ptr <= '0;
        end else if (cmd_strobe) begin
            cpu_ptr <= BANK_W'(ep_access_pkg::LEN_WORD_ADDR);
            cur_ep  <= cmd_ep;
            phase   <= is_wr_cmd ? BUF_WR :
                       is_rd_cmd ? BUF_RD :
                       is_st_cmd ? ST_RD  : IDLE;
        end else if ((data_wr && phase == BUF_WR) ||
                     (data_rd && phase == BUF_RD)) begin
            cpu_ptr <= cpu_ptr + BANK_W'(ep_access_pkg::PTR_STEP);
        end
    end

    // DMA pointer
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dma_ptr  <= '0;
            dma_bank <= 1'b0;
            dma_ep   <= '0;
        end else if (dma_req_i.start) begin
            dma_ptr  <= BANK_W'(ep_access_pkg::DMA_START);
            dma_bank <= 1'b0;
            dma_ep   <= dma_req_i.ep;
        end else if (dma_req_i.step) begin
            if (dma_wrap && double_buf_i[dma_ep] && !dma_bank) begin
                dma_bank <= 1'b1;
                dma_ptr  <= BANK_W'(ep_access_pkg::DMA_START);
            end else begin
                dma_ptr  <= dma_ptr + BANK_W'(ep_access_pkg::PTR_STEP);
            end
        end
    end

    // Status read capture and clear pulse, one cycle after the status data read strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_q         <= ep_access_pkg::ST_RESET;
            event_flag_clr_o <= '0;
        end else begin
            event_flag_clr_o <= '0;
            if (data_rd && phase == ST_RD) begin
                status_q <= status_vec;
                event_flag_clr_o[cur_ep] <= 1'b1;
            end
        end
    end

    // Data outputs from flip-flops: buffer word comes from the RAM register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus_data_o  <= '0;
            dma_data_o  <= '0;
            ram_for_cpu <= 1'b0;
        end else begin
            ram_for_cpu <= cpu_rd_now;
            // Status shows the byte captured at the strobe, before clears
            bus_data_o  <= (phase == ST_RD) ? {8'h00, status_q} : ram_rd;
            // A RAM word fetched for the CPU must not disturb DMA data
            if (!ram_for_cpu) begin
                dma_data_o <= ram_rd;
            end
        end
    end

    // Per-endpoint status flags
    wire st_read = data_rd & (phase == ST_RD);
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            wire ev_stall_set = ep_event_i[g].stall_set;
            wire ev_setup     = ep_event_i[g].setup_rcvd;
            wire rd_this      = st_read && (cur_ep == IDX_W'(g));
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    halted[g]        <= 1'b0;
                    clobbered[g]     <= 1'b0;
                    setup_present[g] <= 1'b0;
                    setup_busy[g]    <= 1'b0;
                    cpu_buf[g]       <= 1'b0;
                end else begin
                    // setup token unstalls, beats stall command
                    if (ev_setup || ep_event_i[g].stall_clr) begin
                        halted[g] <= 1'b0;
                    end else if (ev_stall_set) begin
                        halted[g] <= 1'b1;
                    end
                    // setup_clobbered of pending setup; set beats clear
                    if (ev_setup && setup_present[g]) begin
                        clobbered[g] <= 1'b1;
                    end else if (rd_this && !setup_busy[g]) begin
                        clobbered[g] <= 1'b0;
                    end
                    if (ev_setup) begin
                        setup_busy[g] <= 1'b1;
                    end else if (ep_event_i[g].setup_done) begin
                        setup_busy[g] <= 1'b0;
                    end
                    // setup present until acknowledged or stalled
                    if (ev_setup) begin
                        setup_present[g] <= 1'b1;
                    end else if (ep_event_i[g].setup_ack || ev_stall_set) begin
                        setup_present[g] <= 1'b0;
                    end
                    // CPU bank follows which bank is filled
                    if (double_buf_i[g]) begin
                        cpu_buf[g] <= ep_event_i[g].full1 &
                                      ~ep_event_i[g].full0;
                    end else begin
                        cpu_buf[g] <= 1'b0;
                    end
                end
            end

            setup_unstall_a: assert property (@(posedge core_clk_i)
                disable iff (!rst_n_i)
                ev_setup |=> !halted[g])
                else $error("setup token did not unstall");
            stall_set_a: assert property (@(posedge core_clk_i)
                disable iff (!rst_n_i)
                ev_stall_set && !ev_setup && !ep_event_i[g].stall_clr
                |=> halted[g])
                else $error("stall command did not halt endpoint");
            clobber_set_a: assert property (@(posedge core_clk_i)
                disable iff (!rst_n_i)
                ev_setup && setup_present[g] |=> clobbered[g])
                else $error("setup setup_clobbered not flagged");
            clobber_hold_a: assert property (@(posedge core_clk_i)
                disable iff (!rst_n_i)
                rd_this && setup_busy[g] && clobbered[g] |=> clobbered[g])
                else $error("setup_clobbered flag cleared during setup store");
        end
    endgenerate

    assign endpoint_halted_o = halted;

    // no write path into the status flags
    status_readonly_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (data_wr && phase == ST_RD && !ep_event_i[cur_ep].setup_rcvd &&
         !ep_event_i[cur_ep].stall_set && !ep_event_i[cur_ep].stall_clr)
        |=> halted[$past(cur_ep)] == $past(halted[cur_ep]))
        else $error("status write changed halted flag");

    flag_clear_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        st_read |=> event_flag_clr_o[$past(cur_ep)])
        else $error("status read did not clear event flag");

    sequence buf_cmd_s;
        cmd_strobe && (is_wr_cmd || is_rd_cmd);
    endsequence
    ptr_reset_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        buf_cmd_s |=> cpu_ptr == '0)
        else $error("buffer pointer not reset by command");

    ptr_step_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (data_rd && phase == BUF_RD && !cmd_strobe)
        |=> cpu_ptr == $past(cpu_ptr) + BANK_W'(ep_access_pkg::PTR_STEP))
        else $error("pointer did not advance by two");

    dma_skip_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        dma_req_i.start |=> dma_ptr == BANK_W'(ep_access_pkg::DMA_START) &&
        !dma_bank)
        else $error("dma did not skip length word");

    sequence dma_roll_s;
        dma_req_i.step && !dma_req_i.start && dma_wrap &&
        double_buf_i[dma_ep] && !dma_bank;
    endsequence
    dma_roll_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        dma_roll_s |=> dma_bank &&
        dma_ptr == BANK_W'(ep_access_pkg::DMA_START))
        else $error("dma did not roll to secondary buffer");

    status_cmd_a: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        cmd_strobe && is_st_cmd |=> phase == ST_RD && cur_ep == $past(cmd_ep))
        else $error("status command not decoded");
endmodule

// ### verification/cpu_port_model.sv
/*
 * Behavioural microprocessor on the parallel port: command and data
 * strobes, one word per strobe. Assumes the device samples on the
 * rising edge of core_clk_i and answers reads two edges later.
 */
`timescale 1ns/100ps
module cpu_port_model (
    // Clock
    input  wire logic        core_clk_i,
    // Parallel bus toward the device
    output logic             sel_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic [15:0]      data_o,
    input  wire logic [15:0] data_i
);
    initial begin
        sel_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        data_o = 16'h0000;
    end

    // code on low lines, upper byte junk
    task automatic cmd(input logic [7:0] code, input logic [7:0] junk);
        @(posedge core_clk_i);
        sel_o <= 1'b1;
        wr_o <= 1'b1;
        data_o <= {junk, code};
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        // Released lines show the inverse so stale data never matches
        data_o <= ~{junk, code};
    endtask

    task automatic wr_word(input logic [15:0] w);
        @(posedge core_clk_i);
        sel_o <= 1'b0;
        wr_o <= 1'b1;
        data_o <= w;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        data_o <= ~w;
    endtask

    // one word per strobe, answer after lat edges
    task automatic rd_word(output logic [15:0] w, input int lat);
        @(posedge core_clk_i);
        sel_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        repeat (lat) @(posedge core_clk_i);
        #1 w = data_i;
    endtask
endmodule

// ### verification/endpoint_buffer_access_status_test.sv
/*
 * Self-checking bench for ep_buffer_access: buffer writes and reads
 * through the command port, DMA read start, endpoint status flags.
 * Assumes read data two edges after the strobe; no serial engine.
 */
`timescale 1ns/100ps
module endpoint_buffer_access_status_test;
    localparam int BUF_BYTES = 64;
    localparam int W = BUF_BYTES / 2 + 1;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sel, wr, rd;
    logic [15:0] wdat, rdat, dma_data, flag_clr, halted, db;
    ep_access_pkg::ep_event_t [15:0] ev;
    ep_access_pkg::dma_req_t dma;
    logic [15:0] mem [16][W];
    int cnt [16];
    logic [2:0] lvl [16];
    logic [15:0] halt, setp, clob, busy;
    logic [15:0] w, clr_seen, sec;
    int seed, error_cnt, n_checks, cyc, k, ks, i;

    always #5 core_clk_i = ~core_clk_i;

    // Flag clear is a one-cycle pulse; gather it while it stands
    always @(negedge core_clk_i) clr_seen = clr_seen | flag_clr;

    cpu_port_model cpu_u (.core_clk_i(core_clk_i), .sel_o(sel), .wr_o(wr),
        .rd_o(rd), .data_o(wdat), .data_i(rdat));

    ep_buffer_access #(.BUF_BYTES(BUF_BYTES)) dut_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .command_data_select_i(sel), .bus_wr_i(wr), .bus_rd_i(rd),
        .bus_data_i(wdat), .bus_data_o(rdat), .ep_event_i(ev),
        .double_buf_i(db), .dma_req_i(dma), .dma_data_o(dma_data),
        .event_flag_clr_o(flag_clr), .endpoint_halted_o(halted));

    task conclude;
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_stat(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t status=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] st_exp(input int e);
        return {halt[e], lvl[e][1], lvl[e][2], lvl[e][0], clob[e], setp[e],
                db[e] & lvl[e][1] & ~lvl[e][2], 1'b0};
    endfunction

    // Pulse events and track what the status byte should become
    task automatic ev_pulse(input int e, input logic [7:0] m);
        @(posedge core_clk_i);
        ev[e] <= ep_access_pkg::ep_event_t'(m | {5'h00, lvl[e]});
        @(posedge core_clk_i);
        ev[e] <= ep_access_pkg::ep_event_t'({5'h00, lvl[e]});
        if (m[7]) begin
            halt[e] = 1'b1;
            setp[e] = 1'b0;
        end
        if (m[6]) halt[e] = 1'b0;
        if (m[5]) begin
            clob[e] = clob[e] | setp[e];
            halt[e] = 1'b0;
            busy[e] = 1'b1;
            setp[e] = 1'b1;
        end
        if (m[4]) busy[e] = 1'b0;
        if (m[3]) setp[e] = 1'b0;
    endtask

    task automatic st_check(input int e);
        clr_seen = '0;
        cpu_u.cmd(8'h50 | 8'(e), 8'($random(seed)));
        cpu_u.rd_word(w, 1);
        chk_stat(w[7:0], st_exp(e));
        chk_word(clr_seen, 16'h0001 << e);
        chk_word(halted, halt);
        if (!busy[e]) clob[e] = 1'b0;
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        seed = 32'he18a;
        ev = '0;
        db = 16'h0000;
        dma = '0;
        {halt, setp, clob, busy} = '0;
        for (i = 0; i < 16; i++) lvl[i] = 3'h0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        ks = 2 + int'($unsigned($random(seed)) % 14);
        st_check(ks);
        // write only with write codes, read only after read codes
        for (k = 2; k < 16; k++) begin
            cpu_u.cmd(8'(k), 8'($random(seed)));
            mem[k][0] = 16'h0002;
            mem[k][1] = 16'($random(seed));
            cnt[k] = 2;
            for (i = 0; i < 2; i++) cpu_u.wr_word(mem[k][i]);
        end
        // Full-size packet, N + 2 bytes
        k = 2 + int'($unsigned($random(seed)) % 14);
        cnt[k] = W;
        mem[k][0] = 16'(BUF_BYTES);
        cpu_u.cmd(8'(k), 8'($random(seed)));
        for (i = 0; i < W; i++) begin
            if (i > 0) mem[k][i] = 16'($random(seed));
            cpu_u.wr_word(mem[k][i]);
        end
        // read back only buffers whose writes have completed
        for (ks = 15; ks >= 2; ks--) begin
            cpu_u.cmd(8'h10 | 8'(ks), 8'($random(seed)));
            for (i = 0; i < cnt[ks]; i++) begin
                cpu_u.rd_word(w, 1);
                chk_word(w, mem[ks][i]);
            end
        end
        // Double-buffer k with the CPU on bank 1, then fill its word 1
        @(posedge core_clk_i);
        db <= 16'h0001 << k;
        lvl[k] = 3'h2;
        ev[k] <= ep_access_pkg::ep_event_t'({5'h00, lvl[k]});
        cpu_u.cmd(8'(k), 8'($random(seed)));
        sec = 16'($random(seed));
        cpu_u.wr_word(16'h0002);
        cpu_u.wr_word(sec);
        // DMA read begins at the first data word
        @(posedge core_clk_i);
        dma.start <= 1'b1;
        dma.ep <= 4'(k);
        dma.wdata <= 16'($random(seed));
        @(posedge core_clk_i);
        dma.start <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 chk_word(dma_data, mem[k][1]);
        @(posedge core_clk_i);
        dma.step <= 1'b1;
        @(posedge core_clk_i);
        dma.step <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 chk_word(dma_data, mem[k][2]);
        // Pointer at byte 4: 30 steps reach the end, the 31st rolls over
        @(posedge core_clk_i);
        dma.step <= 1'b1;
        repeat (31) @(posedge core_clk_i);
        dma.step <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 chk_word(dma_data, sec);
        ks = 2 + int'($unsigned($random(seed)) % 14);
        ev_pulse(ks, 8'h80);
        st_check(ks);
        ev_pulse(ks, 8'h40);
        st_check(ks);
        ev_pulse(ks, 8'h80);
        ev_pulse(ks, 8'h20);
        ev_pulse(ks, 8'h10);
        st_check(ks);
        // firmware rereads status before acting on setup data
        ev_pulse(ks, 8'h20);
        st_check(ks);
        ev_pulse(ks, 8'h10);
        st_check(ks);
        st_check(ks);
        cpu_u.cmd(8'h50 | 8'(ks), 8'h00);
        cpu_u.wr_word(16'($random(seed)));
        st_check(ks);
        ev_pulse(ks, 8'h08);
        st_check(ks);
        for (i = 0; i < 8; i++) begin
            lvl[ks] = 3'($random(seed));
            @(posedge core_clk_i);
            ev[ks] <= ep_access_pkg::ep_event_t'({5'h00, lvl[ks]});
            db <= 16'($random(seed));
            @(posedge core_clk_i);
            st_check(ks);
        end
        conclude();
    end
endmodule
